/* logic/sfc_top.sv */
`timescale 1ns/1ns
`include "sfc_defines.svh"
module sfc_top (
  input logic clk_i,
  input logic rst_n_i,
  input logic ce_i,
  input logic mclk_i,
  input logic channel_select_clk_i,
  input logic serial_audio_in_i,
  input logic deemph_or_bitclk_pin_i,
  input logic sample_ready_i,
  output logic sample_valid_o,
  output logic [`SFC_WORD_W-1:0] sample_data_o,
  output logic sample_right_o,
  output logic deemph_o,
  output logic ext_bitclk_mode_o,
  output logic power_down_o,
  output logic overrun_o,
  output logic [`SFC_CFG_W-1:0] cfg_o
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [`SFC_PIN_N-1:0] p_lvl, p_rise, p_fall;
  logic mclk_rise, lr_lvl, lr_rise, lr_fall, lr_edge, sd_lvl, dual_lvl, dual_rise, dual_fall;

  sfc_pin_sync #(.W(`SFC_PIN_N)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .pin_i({deemph_or_bitclk_pin_i, serial_audio_in_i, channel_select_clk_i, mclk_i}),
    .lvl_o(p_lvl),
    .rise_o(p_rise),
    .fall_o(p_fall)
  );

  assign mclk_rise = p_rise[`SFC_PIN_MCLK];
  assign lr_lvl = p_lvl[`SFC_PIN_CHANNEL_SELECT_CLK];
  assign lr_rise = p_rise[`SFC_PIN_CHANNEL_SELECT_CLK];
  assign lr_fall = p_fall[`SFC_PIN_CHANNEL_SELECT_CLK];
  assign lr_edge = lr_rise | lr_fall;
  assign sd_lvl = p_lvl[`SFC_PIN_SDAT];
  assign dual_lvl = p_lvl[`SFC_PIN_DUAL];
  assign dual_rise = p_rise[`SFC_PIN_DUAL];
  assign dual_fall = p_fall[`SFC_PIN_DUAL];

  ////////////////////////////////////////////////////////////////////////
  // clock monitor: master clocks per frame, idle times, shared pin edges
  logic [`SFC_MCNT_W-1:0] mcnt_r, mcnt_nxt;
  sfc_pkg::sfc_ratio_t ratio_r, ratio_nxt;
  logic [`SFC_CYC_W-1:0] lr_idle_r, lr_idle_nxt, lr_per_r, lr_per_nxt;
  logic [`SFC_IDLE_W-1:0] mk_idle_r, mk_idle_nxt;
  logic [`SFC_EDGE_W-1:0] dedge_r, dedge_nxt;

  always_comb
  begin
    mcnt_nxt = mcnt_r;
    ratio_nxt = ratio_r;
    lr_idle_nxt = lr_idle_r;
    lr_per_nxt = lr_per_r;
    mk_idle_nxt = mk_idle_r;
    dedge_nxt = dedge_r;
    if (ce_i)
    begin
      if (mclk_rise)
        mk_idle_nxt = '0;
      else if (mk_idle_r != '1)
        mk_idle_nxt = mk_idle_r + 1'b1;
      if (lr_rise)
      begin
        // classify the frame just ended
        if (mcnt_r < `SFC_MCNT_T1)
          ratio_nxt = sfc_pkg::SFC_R256;
        else if (mcnt_r < `SFC_MCNT_T2)
          ratio_nxt = sfc_pkg::SFC_R384;
        else
          ratio_nxt = sfc_pkg::SFC_R512;
        mcnt_nxt = '0;
        lr_per_nxt = lr_idle_r;
        lr_idle_nxt = '0;
        dedge_nxt = '0;
      end
      else
      begin
        if (mclk_rise && mcnt_r != '1)
          mcnt_nxt = mcnt_r + 1'b1;
        if (lr_idle_r != '1)
          lr_idle_nxt = lr_idle_r + 1'b1;
        if (dual_rise && dedge_r != '1)
          dedge_nxt = dedge_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      mcnt_r <= '0;
      ratio_r <= sfc_pkg::SFC_R256;
      lr_idle_r <= '0;
      lr_per_r <= '0;
      mk_idle_r <= '1;
      dedge_r <= '0;
    end
    else
    begin
      mcnt_r <= mcnt_nxt;
      ratio_r <= ratio_nxt;
      lr_idle_r <= lr_idle_nxt;
      lr_per_r <= lr_per_nxt;
      mk_idle_r <= mk_idle_nxt;
      dedge_r <= dedge_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode machine: power-down, internal bit clock, external bit clock
  sfc_pkg::sfc_mode_t mode_r, mode_nxt;
  logic ext_r, ext_nxt, pd_r, pd_nxt, lost, mk_alive;

  assign mk_alive = mk_idle_r < `SFC_MCLK_IDLE;
  assign lost = !mk_alive || (lr_per_r != '0 && lr_idle_r > lr_per_r);

  always_comb
  begin
    mode_nxt = mode_r;
    if (ce_i)
    begin
      case (mode_r)
        sfc_pkg::SFC_PWR_DOWN:
          if (lr_rise && mk_alive && lr_per_r != '0)
            mode_nxt = sfc_pkg::SFC_RUN_INT;
        sfc_pkg::SFC_RUN_INT:
          if (lost)
            mode_nxt = sfc_pkg::SFC_PWR_DOWN;
          else if (lr_rise && dedge_r >= `SFC_EXT_EDGES)
            mode_nxt = sfc_pkg::SFC_RUN_EXT;
        sfc_pkg::SFC_RUN_EXT:
          if (lost)
            mode_nxt = sfc_pkg::SFC_PWR_DOWN;
        default:
          mode_nxt = sfc_pkg::SFC_PWR_DOWN;
      endcase
    end
    ext_nxt = mode_nxt == sfc_pkg::SFC_RUN_EXT;
    pd_nxt = mode_nxt == sfc_pkg::SFC_PWR_DOWN;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      mode_r <= sfc_pkg::SFC_PWR_DOWN;
      ext_r <= 1'b0;
      pd_r <= 1'b1;
    end
    else
    begin
      mode_r <= mode_nxt;
      ext_r <= ext_nxt;
      pd_r <= pd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // format register, loaded by the serial code on the shared pin
  sfc_pkg::sfc_cfg_t cfg_r, cfg_nxt;
  logic [`SFC_CBIT_W-1:0] cbit_r, cbit_nxt;
  logic [`SFC_CODE_W-1:0] code_r, code_nxt, code_word;
  logic code_done, code_ok;

  assign code_word = {code_r[`SFC_CODE_W-2:0], dual_lvl};
  assign code_done = ce_i && sd_lvl && lr_fall && cbit_r == `SFC_CODE_LAST;
  assign code_ok = code_word[`SFC_CODE_W-1 -: `SFC_PRE_W] == `SFC_PRE_VAL
    && code_word != `SFC_ERR_CODE;

  always_comb
  begin
    cbit_nxt = cbit_r;
    code_nxt = code_r;
    cfg_nxt = cfg_r;
    if (ce_i)
    begin
      if (!sd_lvl)
        cbit_nxt = '0;
      else if (lr_fall)
      begin
        code_nxt = code_word;
        cbit_nxt = cbit_r + 1'b1;
      end
      if (code_done && code_ok && !ext_r)
        cfg_nxt = code_word[`SFC_CFG_W-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cbit_r <= '0;
      code_r <= '0;
      cfg_r <= `SFC_CFG_DEFAULT;
    end
    else
    begin
      cbit_r <= cbit_nxt;
      code_r <= code_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit strobe: divided master clock or selected edge of the shared pin
  logic [`SFC_DIV_W-1:0] div_r, div_nxt, div_sel;
  logic bit_stb, int_stb;

  function automatic logic [`SFC_DIV_W-1:0] bit_div(input sfc_pkg::sfc_ratio_t rt,
                                                   input logic [1:0] fld);
    logic [`SFC_DIV_W-1:0] d;
    d = `SFC_DIV8;
    case (rt)
      sfc_pkg::SFC_R384: d = `SFC_DIV8;
      sfc_pkg::SFC_R256: d = fld == `SFC_RAT32 ? `SFC_DIV8 :
                             fld == `SFC_RAT128 ? `SFC_DIV2 : `SFC_DIV4;
      sfc_pkg::SFC_R512: d = fld == `SFC_RAT32 ? `SFC_DIV16 :
                             fld == `SFC_RAT128 ? `SFC_DIV4 : `SFC_DIV8;
      default: d = `SFC_DIV8;
    endcase
    return d;
  endfunction : bit_div

  assign div_sel = bit_div(ratio_r, {cfg_r.ratio_or_edge_hi, cfg_r.ratio_or_edge_lo});
  assign int_stb = mclk_rise && div_r == div_sel - 1'b1;
  assign bit_stb = ext_r ? (cfg_r.ratio_or_edge_lo ? dual_fall : dual_rise)
    : (mode_r == sfc_pkg::SFC_RUN_INT && int_stb);

  always_comb
  begin
    div_nxt = div_r;
    if (ce_i)
    begin
      if (lr_edge || int_stb)
        div_nxt = '0;
      else if (mclk_rise)
        div_nxt = div_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      div_r <= '0;
    else
      div_r <= div_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // word assembly, msb first, justified per format register
  logic [`SFC_WORD_W-1:0] sh_r, sh_nxt;
  logic [`SFC_BCNT_W-1:0] bcnt_r, bcnt_nxt, bcnt_base, tgt;
  logic chan_r, chan_nxt, wv_r, wv_nxt, ovr_r, ovr_nxt, emit, dem_r, dem_nxt;
  logic [`SFC_WORD_W:0] wd_r, wd_nxt, emit_word;

  function automatic logic [`SFC_WORD_W-1:0] fmt_word(input logic [`SFC_WORD_W-1:0] s,
                                                      input logic len16);
    return len16 ? {s[`SFC_WORD_W-3:0], `SFC_PAD16} : s;
  endfunction : fmt_word

  sfc_stream_if #(.W(`SFC_WORD_W + 1)) buf_in ();
  sfc_stream_if #(.W(`SFC_WORD_W + 1)) buf_out ();

  assign bcnt_base = lr_edge ? '0 : bcnt_r;
  assign tgt = (cfg_r.word_len_sel ? `SFC_WLEN16 : `SFC_WLEN18)
    + {{(`SFC_BCNT_W-1){1'b0}}, cfg_r.i2s_format_en};

  always_comb
  begin
    sh_nxt = sh_r;
    bcnt_nxt = bcnt_r;
    chan_nxt = chan_r;
    wv_nxt = wv_r;
    wd_nxt = wd_r;
    ovr_nxt = ovr_r;
    emit = 1'b0;
    emit_word = '0;
    dem_nxt = dem_r;
    if (ce_i)
    begin
      dem_nxt = mode_r == sfc_pkg::SFC_RUN_INT && dual_lvl;
      if (lr_edge)
      begin
        chan_nxt = cfg_r.i2s_format_en ? lr_lvl : ~lr_lvl;
        if (cfg_r.justify_sel && !pd_r)
        begin
          emit = 1'b1;
          emit_word = {chan_r, fmt_word(sh_r, cfg_r.word_len_sel)};
        end
      end
      bcnt_nxt = bcnt_base;
      if (bit_stb)
      begin
        sh_nxt = {sh_r[`SFC_WORD_W-2:0], sd_lvl};
        if (bcnt_base != '1)
          bcnt_nxt = bcnt_base + 1'b1;
        if (!cfg_r.justify_sel && bcnt_nxt == tgt)
        begin
          emit = 1'b1;
          emit_word = {chan_nxt, fmt_word(sh_nxt, cfg_r.word_len_sel)};
        end
      end
      if (buf_in.ready)
        wv_nxt = 1'b0;
      if (emit)
      begin
        if (wv_r && !buf_in.ready)
          ovr_nxt = 1'b1;
        else
        begin
          wv_nxt = 1'b1;
          wd_nxt = emit_word;
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sh_r <= '0;
      bcnt_r <= '0;
      chan_r <= 1'b0;
      wv_r <= 1'b0;
      wd_r <= '0;
      ovr_r <= 1'b0;
      dem_r <= 1'b0;
    end
    else
    begin
      sh_r <= sh_nxt;
      bcnt_r <= bcnt_nxt;
      chan_r <= chan_nxt;
      wv_r <= wv_nxt;
      wd_r <= wd_nxt;
      ovr_r <= ovr_nxt;
      dem_r <= dem_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output buffer and ports
  assign buf_in.valid = wv_r;
  assign buf_in.data = wd_r;
  assign buf_out.ready = sample_ready_i;

  sfc_skid_buf #(.W(`SFC_WORD_W + 1)) u_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .in_if(buf_in),
    .out_if(buf_out)
  );

  assign sample_valid_o = buf_out.valid;
  assign sample_data_o = buf_out.data[`SFC_WORD_W-1:0];
  assign sample_right_o = buf_out.data[`SFC_WORD_W];
  assign deemph_o = dem_r;
  assign ext_bitclk_mode_o = ext_r;
  assign power_down_o = pd_r;
  assign overrun_o = ovr_r;
  assign cfg_o = cfg_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_pre_deny: assert property (
    code_done && code_word[`SFC_CODE_W-1 -: `SFC_PRE_W] != `SFC_PRE_VAL |=> $stable(cfg_r))
    else $error("register changed behind a bad preamble");
  chk_err_code: assert property (code_done && code_word == `SFC_ERR_CODE |=> $stable(cfg_r))
    else $error("error code changed register");
  chk_ext_lock: assert property (ext_r |=> $stable(cfg_r))
    else $error("register changed in external mode");
  chk_cfg_load: assert property (code_done && code_ok && !ext_r
    |=> cfg_r == $past(code_word[`SFC_CFG_W-1:0]))
    else $error("valid code not loaded");
  chk_serial_audio_in_abort: assert property (ce_i && !sd_lvl |=> cbit_r == '0)
    else $error("code bits kept while serial input low");
  chk_ratio_384: assert property (ratio_r == sfc_pkg::SFC_R384 |-> div_sel == `SFC_DIV8)
    else $error("384 ratio not giving 48 per frame");
  chk_pd_enter: assert property (ce_i && !pd_r && lost |=> pd_r && power_down_o)
    else $error("no power-down after clock loss");
  chk_deemph_ext: assert property (ext_r ##1 ext_r |-> !deemph_o)
    else $error("de-emphasis driven in external mode");
  chk_ovr_stall: assert property (wv_r && !buf_in.ready && emit |=> ovr_r && wv_r)
    else $error("stalled word lost");

  cov_cfg_load: cover property (code_done && code_ok && !ext_r);
  cov_ext_mode: cover property (!ext_r ##1 ext_r);
  cov_pd_exit: cover property (pd_r ##1 !pd_r);
  cov_overrun: cover property (!ovr_r ##1 ovr_r);
endmodule : sfc_top

/* logic/sfc_defines.svh */
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH
// Notes on behaviour
// - a 5-bit format register picks format, bit-clock rate, sampling edge, word length
// - a write is 8 code bits: 3 preamble bits then 5 register bits
// - one code bit per falling channel clock edge, preamble first, word length last
// - register loads only behind preamble 0,1,0; any other preamble is denied
// - the full code 01000000 is an error and is dropped
// - writes are refused while in external bit-clock mode; after power-down they are taken again
// - register powers up holding the default format, no write needed
// - internal mode ratio field: 00 gives 32, 10 gives 64, 11 gives 128
// - a 384 master ratio forces an internal bit clock of 48 per frame
// - external mode field: 10 samples on rising, 11 on falling bit-clock edge
// - justify field: 0 left justified, 1 right justified to channel edge
// - i2s field 1 enables i2s; i2s needs justify 0 and i2s 1
// - word length field: 0 loads 18 bits, 1 loads 16 bits
// - channel clock level tells left from right for each word
// - samples are two's complement, most significant bit first
// - shared pin is de-emphasis in internal mode, bit clock in external mode
// - power-down within one frame after master or channel clock stops

// configuration code
`define SFC_CFG_W 5
`define SFC_CODE_W 8
`define SFC_PRE_W 3
`define SFC_PRE_VAL 3'h2
`define SFC_ERR_CODE 8'h40
`define SFC_CFG_DEFAULT 5'h14
`define SFC_CBIT_W 3
`define SFC_CODE_LAST 3'h7
// ratio field encodings
`define SFC_RAT32 2'h0
`define SFC_RAT128 2'h3
// master clock per bit clock
`define SFC_DIV_W 5
`define SFC_DIV2 5'h02
`define SFC_DIV4 5'h04
`define SFC_DIV8 5'h08
`define SFC_DIV16 5'h10
// master clocks per frame thresholds
`define SFC_MCNT_W 10
`define SFC_MCNT_T1 10'h140
`define SFC_MCNT_T2 10'h1c0
// timeouts and detection
`define SFC_CYC_W 16
`define SFC_IDLE_W 8
`define SFC_MCLK_IDLE 8'h20
`define SFC_EDGE_W 8
`define SFC_EXT_EDGES 8'h10
// audio words
`define SFC_WORD_W 18
`define SFC_BCNT_W 5
`define SFC_WLEN16 5'h10
`define SFC_WLEN18 5'h12
`define SFC_PAD16 2'h0
// synchroniser lanes
`define SFC_PIN_N 4
`define SFC_PIN_MCLK 0
`define SFC_PIN_CHANNEL_SELECT_CLK 1
`define SFC_PIN_SDAT 2
`define SFC_PIN_DUAL 3
`endif

/* logic/sfc_pkg.sv */
package sfc_pkg;
  // link operating mode, gray along power-down, internal, external
  typedef enum logic [1:0] {
    SFC_PWR_DOWN = 2'h0,
    SFC_RUN_INT = 2'h1,
    SFC_RUN_EXT = 2'h3
  } sfc_mode_t;
  // measured master clock per frame
  typedef enum logic [1:0] {
    SFC_R256 = 2'h0,
    SFC_R384 = 2'h1,
    SFC_R512 = 2'h3
  } sfc_ratio_t;
  // format register layout, first written bit on top
  typedef struct packed {
    logic ratio_or_edge_hi;
    logic ratio_or_edge_lo;
    logic justify_sel;
    logic i2s_format_en;
    logic word_len_sel;
  } sfc_cfg_t;
endpackage : sfc_pkg

/* logic/sfc_stream_if.sv */
`timescale 1ns/1ns
interface sfc_stream_if #(parameter int W = 19);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sfc_stream_if

/* logic/sfc_pin_sync.sv */
`timescale 1ns/1ns
module sfc_pin_sync #(parameter int W = 4) (
  input logic clk_i,
  input logic rst_n_i,
  input logic ce_i,
  input logic [W-1:0] pin_i,
  output logic [W-1:0] lvl_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  logic [W-1:0] meta_r, meta_nxt, sync_r, sync_nxt, last_r, last_nxt;

  // two stages, then one more for edge finding
  always_comb
  begin
    meta_nxt = meta_r;
    sync_nxt = sync_r;
    last_nxt = last_r;
    if (ce_i)
    begin
      meta_nxt = pin_i;
      sync_nxt = meta_r;
      last_nxt = sync_r;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= '0;
      sync_r <= '0;
      last_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
    end
  end

  // per-lane level and edges, only from the second stage on
  for (genvar g = 0; g < W; g++)
  begin : g_lane
    assign lvl_o[g] = sync_r[g];
    assign rise_o[g] = ce_i & sync_r[g] & ~last_r[g];
    assign fall_o[g] = ce_i & ~sync_r[g] & last_r[g];
  end
endmodule : sfc_pin_sync

/* logic/sfc_skid_buf.sv */
`timescale 1ns/1ns
module sfc_skid_buf #(parameter int W = 19) (
  input logic clk_i,
  input logic rst_n_i,
  input logic ce_i,
  sfc_stream_if.snk in_if,
  sfc_stream_if.src out_if
);
  logic o_vld_r, o_vld_nxt, s_vld_r, s_vld_nxt, rdy_r, rdy_nxt, take;
  logic [W-1:0] o_dat_r, o_dat_nxt, s_dat_r, s_dat_nxt;

  // two entries: output stage and skid stage
  always_comb
  begin
    o_vld_nxt = o_vld_r;
    o_dat_nxt = o_dat_r;
    s_vld_nxt = s_vld_r;
    s_dat_nxt = s_dat_r;
    take = ce_i & in_if.valid & rdy_r;
    if (ce_i)
    begin
      if (!o_vld_r || out_if.ready)
      begin
        if (s_vld_r)
        begin
          o_vld_nxt = 1'b1;
          o_dat_nxt = s_dat_r;
          s_vld_nxt = 1'b0;
        end
        else
        begin
          o_vld_nxt = take;
          o_dat_nxt = take ? in_if.data : o_dat_r;
        end
      end
      else if (take)
      begin
        s_vld_nxt = 1'b1;
        s_dat_nxt = in_if.data;
      end
    end
    rdy_nxt = ~s_vld_nxt;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      o_vld_r <= 1'b0;
      o_dat_r <= '0;
      s_vld_r <= 1'b0;
      s_dat_r <= '0;
      rdy_r <= 1'b1;
    end
    else
    begin
      o_vld_r <= o_vld_nxt;
      o_dat_r <= o_dat_nxt;
      s_vld_r <= s_vld_nxt;
      s_dat_r <= s_dat_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  assign out_if.valid = o_vld_r;
  assign out_if.data = o_dat_r;
  assign in_if.ready = rdy_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_stall_hold: assert property (o_vld_r && !out_if.ready |=> o_vld_r && $stable(o_dat_r))
    else $error("word changed while receiver stalled");
  chk_take_land: assert property (ce_i && in_if.valid && rdy_r |=> o_vld_r)
    else $error("accepted word not held in buffer");
endmodule : sfc_skid_buf

/* tb/sfc_src_model.sv */
`timescale 1ns/1ns
// audio source: master clock, channel clock, data and shared pin
module sfc_src_model (
  output logic mclk_o,
  output logic chan_o,
  output logic sdat_o,
  output logic pin_o
);
  ////////////////////////////////////////
  // idle levels, then a free master clock of 256 per frame
  initial
  begin
    mclk_o = 1'b0;
    chan_o = 1'b0;
    sdat_o = 1'b0;
    pin_o = 1'b0;
    #7;
    forever
      #40 mclk_o = ~mclk_o;
  end

  ////////////////////////////////////////
  // one channel period, code bit stable around the falling edge
  task automatic cfg_bit(input logic b, input logic sd);
    pin_o = b;
    sdat_o = sd;
    chan_o = 1'b1;
    #10240;
    chan_o = 1'b0;
    #10240;
  endtask : cfg_bit

  // eight code bits, first bit first, data line low from bit drop on
  task automatic cfg_write(input logic [7:0] code, input int drop);
    for (int i = 0; i < 8; i++)
      cfg_bit(code[7 - i], i < drop);
  endtask : cfg_write

  // frame of 2 x 32 bit clocks, channel high for the left word
  task automatic frame(input logic fall, input logic lj, input int n,
                       input logic [17:0] wl, input logic [17:0] wr);
    logic [17:0] w;
    int j;
    for (int k = 0; k < 64; k++)
    begin
      w = (k < 32) ? wl : wr;
      j = lj ? n - 1 - k % 32 : 31 - k % 32;
      chan_o = (k < 32);
      pin_o = fall;
      sdat_o = (j >= 0 && j < n) ? w[j] : k[0];
      #160;
      pin_o = ~fall;
      #160;
    end
  endtask : frame
endmodule : sfc_src_model

/* tb/tb_top.sv */
`timescale 1ns/1ns
`include "sfc_defines.svh"
// self-checking bench for the serial format block
module tb_top;
  logic clk_i, rst_n_i, ce_i, sample_ready_i, mclk, chan, sdat, pin;
  logic sample_valid_o, sample_right_o, deemph_o, ext_bitclk_mode_o, power_down_o, overrun_o;
  logic [`SFC_WORD_W-1:0] sample_data_o;
  logic [`SFC_CFG_W-1:0] cfg_o, cfg_exp;
  logic [4:0] st;
  logic [18:0] exp_q[$];
  logic armed, stall;
  logic [31:0] rnd = 32'h00016a82;
  logic [31:0] wseed = 32'h00016a82;
  int n_fail = 0;
  int num_checks = 0;

  // status flags gathered for compact compares
  assign st = {sample_valid_o, overrun_o, ext_bitclk_mode_o, power_down_o, deemph_o};

  ////////////////////////////////////////
  // device and audio source
  sfc_top u_dut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .mclk_i(mclk),
    .channel_select_clk_i(chan),
    .serial_audio_in_i(sdat),
    .deemph_or_bitclk_pin_i(pin),
    .sample_ready_i(sample_ready_i),
    .sample_valid_o(sample_valid_o),
    .sample_data_o(sample_data_o),
    .sample_right_o(sample_right_o),
    .deemph_o(deemph_o),
    .ext_bitclk_mode_o(ext_bitclk_mode_o),
    .power_down_o(power_down_o),
    .overrun_o(overrun_o),
    .cfg_o(cfg_o)
  );
  sfc_src_model u_src (
    .mclk_o(mclk),
    .chan_o(chan),
    .sdat_o(sdat),
    .pin_o(pin)
  );

  ////////////////////////////////////////
  // system clock
  initial
  begin
    clk_i = 1'b0;
    forever
      #20 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [18:0] e, input logic [18:0] s);
    num_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask : check

  task automatic timeout(input string what);
    n_fail++;
    $display("[ERR] %s expected done seen timeout", what);
    summarize();
  endtask : timeout

  // random receiver ready, low throughout a stall
  always @(negedge clk_i)
  begin
    rnd = xs(rnd);
    sample_ready_i <= ~stall & rnd[0];
  end

  // oldest note against each word taken
  always @(posedge clk_i)
    if (armed && sample_valid_o === 1'b1 && sample_ready_i === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("extra word", 19'h0, {sample_right_o, sample_data_o});
      else
        check("word", exp_q.pop_front(), {sample_right_o, sample_data_o});
    end

  ////////////////////////////////////////
  // reset pulse with outputs at their reset levels
  task automatic rst_chk;
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    cfg_exp = 5'h14;
    check("reset", 19'h54, {9'h0, st, cfg_o});
  endtask : rst_chk

  // one code write, then the register compared
  task automatic wr(input logic [7:0] code, input int drop, input logic ok);
    u_src.cfg_write(code, drop);
    if (ok)
      cfg_exp = code[4:0];
    @(negedge clk_i);
    check("cfg", {14'h0, cfg_exp}, {14'h0, cfg_o});
  endtask : wr

  // wait for every noted word, then stop comparing
  task automatic drain;
    int t;
    for (t = 0; t < 600 && exp_q.size() != 0; t++)
      @(negedge clk_i);
    armed = 1'b0;
    if (t == 600)
      timeout("words");
  endtask : drain

  // frames of random words, noting those after the warm-up
  task automatic play(input int warm, input int nf, input logic fall, input logic lj,
                      input int n);
    logic [17:0] wl, wrt;
    for (int f = 0; f <= warm + nf; f++)
    begin
      wseed = xs(wseed);
      wl = wseed[17:0];
      wseed = xs(wseed);
      wrt = wseed[17:0];
      if (f >= warm && f < warm + nf)
      begin
        // n of 17 means i2s: one lead bit, channel sense swapped
        exp_q.push_back({n == 17, (n == 18) ? wl : {wl[15:0], 2'h0}});
        exp_q.push_back({n != 17, (n == 18) ? wrt : {wrt[15:0], 2'h0}});
      end
      fork
        u_src.frame(fall, lj, n, wl, wrt);
        begin
          if (f == warm)
          begin
            repeat (40) @(negedge clk_i);
            armed = 1'b1;
          end
          if (f == warm + nf)
            drain();
        end
      join
    end
  endtask : play

  ////////////////////////////////////////
  // main sequence
  initial
  begin
    int t;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    stall = 1'b0;
    armed = 1'b0;
    rst_chk();
    for (int p = 0; p < 8; p++)
      wr({p[2:0], 5'h02}, 8, p == 2);
    wr(8'h40, 8, 1'b0);
    wr(8'h59, 4, 1'b0);
    wr(8'h59, 8, 1'b1);
    $display("test config writes done");
    repeat (3) u_src.cfg_bit(1'b1, 1'b0);
    check("int mode", 19'h1, {16'h0, st[2:0]});
    play(2, 4, 1'b1, 1'b1, 16);
    check("ext mode", 19'h4, {16'h0, st[2:0]});
    wr(8'h42, 8, 1'b0);
    $display("test external left 16 done");
    for (t = 0; t < 1100 && power_down_o !== 1'b1; t++)
      @(negedge clk_i);
    if (t == 1100)
      timeout("power down");
    check("stopped", 19'h2, {16'h0, st[2:0]});
    $display("test power down done");
    rst_chk();
    play(3, 4, 1'b0, 1'b0, 18);
    $display("test external right 18 done");
    stall = 1'b1;
    play(3, 0, 1'b0, 1'b0, 18);
    check("overrun", 19'h1, {18'h0, overrun_o});
    stall = 1'b0;
    for (t = 0; t < 100 && sample_valid_o !== 1'b0; t++)
      @(negedge clk_i);
    if (t == 100)
      timeout("buffer drain");
    $display("test buffer stall done");
    rst_chk();
    wr(8'h53, 8, 1'b1);
    play(3, 2, 1'b0, 1'b1, 17);
    $display("test i2s 16 done");
    summarize();
  end
endmodule : tb_top
